// ### verilog/csp_core_regs.sv
`timescale 1ns/10ps
`include "csp_regs.svh"
module csp_core_regs
  import csp_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // special-function register access
  input wire csp_pkg::csp_byte_t sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire csp_pkg::csp_byte_t sfr_wdata,
  output csp_pkg::csp_byte_t sfr_rdata,
  output logic sfr_hit,
  // datapath updates
  input wire logic push_req,
  input wire logic acc_load,
  input wire csp_pkg::csp_byte_t acc_value,
  input wire csp_pkg::csp_op_t arith_op,
  input wire csp_pkg::csp_byte_t arith_b,
  // state to datapath
  output csp_pkg::csp_byte_t stack_top_pointer,
  output csp_pkg::csp_byte_t push_addr,
  output logic push_strobe,
  output logic [15:0] indirect_pointer,
  output csp_pkg::csp_byte_t program_status_word,
  output csp_pkg::csp_byte_t accumulator,
  output logic [4:0] bank_base
);
  import csp_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  csp_byte_t sp_ff, dpl_ff, dph_ff, psw_ff, acc_ff;
  csp_byte_t nxt_sp;
  csp_byte_t rdata_ff;
  logic hit_ff;
  csp_byte_t push_addr_ff;
  logic push_strobe_ff;
  logic fl_carry, fl_half, fl_ovf, fl_ovf_touch;
  logic arith_touch;
  logic wr_sp, wr_dpl, wr_dph, wr_psw, wr_acc;
  logic parity;
  assign wr_sp = sfr_wr && (sfr_addr == `CSP_ADDR_STACK_TOP);
  assign wr_dpl = sfr_wr && (sfr_addr == `CSP_ADDR_PTR_LOW);
  assign wr_dph = sfr_wr && (sfr_addr == `CSP_ADDR_PTR_HIGH);
  assign wr_psw = sfr_wr && (sfr_addr == `CSP_ADDR_STATUS);
  assign wr_acc = sfr_wr && (sfr_addr == `CSP_ADDR_ACCUM);
  assign arith_touch = (arith_op == CSP_OP_ADD) ||
    (arith_op == CSP_OP_ADD_WITH_CARRY) || (arith_op == CSP_OP_SUBTRACT_WITH_BORROW) ||
    (arith_op == CSP_OP_OTHER) || (arith_op == CSP_OP_MUL) ||
    (arith_op == CSP_OP_DIV);
  ////////////////////////////////////////////////////////////////////////
  // flags from current accumulator and operand
  csp_flag_unit i_csp_flag_unit (
    .op(arith_op),
    .opnd_a(acc_ff),
    .opnd_b(arith_b),
    .carry_in(psw_ff[`CSP_BIT_CARRY]),
    .carry_out(fl_carry),
    .half_out(fl_half),
    .ovf_out(fl_ovf),
    .ovf_touch(fl_ovf_touch)
  );
  ////////////////////////////////////////////////////////////////////////
  // stack pointer: push wins over a same-cycle write, it is the datapath's
  assign nxt_sp = sp_ff + 8'h01;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sp_ff <= `CSP_RST_STACK_TOP;
    end else if (push_req) begin
      sp_ff <= nxt_sp;
    end else if (wr_sp) begin
      sp_ff <= sfr_wdata;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      push_addr_ff <= 8'h00;
      push_strobe_ff <= 1'b0;
    end else begin
      push_strobe_ff <= push_req;
      if (push_req) begin
        push_addr_ff <= nxt_sp;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // indirect pointer bytes
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dpl_ff <= `CSP_RST_PTR_LOW;
      dph_ff <= `CSP_RST_PTR_HIGH;
    end else begin
      if (wr_dpl) begin
        dpl_ff <= sfr_wdata;
      end
      if (wr_dph) begin
        dph_ff <= sfr_wdata;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // accumulator: software write wins over datapath load
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      acc_ff <= `CSP_RST_ACCUM;
    end else if (wr_acc) begin
      acc_ff <= sfr_wdata;
    end else if (acc_load) begin
      acc_ff <= acc_value;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // status word; parity bit is never stored, it follows the accumulator
  csp_byte_t nxt_psw;
  always_comb begin
    nxt_psw = psw_ff;
    if (wr_psw) begin
      nxt_psw = sfr_wdata;
    end else if (arith_touch) begin
      nxt_psw[`CSP_BIT_CARRY] = fl_carry;
      nxt_psw[`CSP_BIT_HALF] = fl_half;
      if (fl_ovf_touch) begin
        nxt_psw[`CSP_BIT_OVERFLOW] = fl_ovf;
      end
    end
    // a write to the read-only bit is dropped
    nxt_psw[`CSP_BIT_PARITY] = 1'b0;
  end
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      psw_ff <= `CSP_RST_STATUS;
    end else begin
      psw_ff <= nxt_psw;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // named status fields; user flags and bank bits see software only
  logic carry_flag, half_carry_flag, user_flag_a, overflow_flag;
  logic bank_select_high, bank_select_low, user_flag_b;
  csp_byte_t psw_view;
  assign carry_flag = psw_ff[`CSP_BIT_CARRY];
  assign half_carry_flag = psw_ff[`CSP_BIT_HALF];
  assign user_flag_a = psw_ff[`CSP_BIT_USER_A];
  assign bank_select_high = psw_ff[`CSP_BIT_BANK_HI];
  assign bank_select_low = psw_ff[`CSP_BIT_BANK_LO];
  assign overflow_flag = psw_ff[`CSP_BIT_OVERFLOW];
  assign user_flag_b = psw_ff[`CSP_BIT_USER_B];
  assign psw_view = {carry_flag, half_carry_flag, user_flag_a,
    bank_select_high, bank_select_low, overflow_flag, user_flag_b, parity};
  ////////////////////////////////////////////////////////////////////////
  // parity as an xor chain, one stage per accumulator bit
  logic [8:0] par_chain;
  assign par_chain[0] = 1'b0;
  for (genvar gi = 0; gi < 8; gi++) begin : g_parity
    assign par_chain[gi+1] = par_chain[gi] ^ acc_ff[gi];
  end
  assign parity = par_chain[8];
  ////////////////////////////////////////////////////////////////////////
  // read path, one cycle latency; reserved locations are not claimed
  csp_byte_t nxt_rdata;
  logic nxt_hit;
  always_comb begin
    nxt_hit = 1'b0;
    nxt_rdata = 8'h00;
    if (sfr_rd) begin
      nxt_hit = 1'b1;
      case (sfr_addr)
        `CSP_ADDR_STACK_TOP: nxt_rdata = sp_ff;
        `CSP_ADDR_PTR_LOW: nxt_rdata = dpl_ff;
        `CSP_ADDR_PTR_HIGH: nxt_rdata = dph_ff;
        `CSP_ADDR_STATUS: nxt_rdata = psw_view;
        `CSP_ADDR_ACCUM: nxt_rdata = acc_ff;
        default: nxt_hit = 1'b0;
      endcase
    end
  end
  // registered so the bus sees a clean value for the whole cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rdata_ff <= 8'h00;
      hit_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      hit_ff <= nxt_hit;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // registered copies for the datapath
  csp_byte_t psw_out_ff;
  logic [4:0] bank_ff;
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      psw_out_ff <= `CSP_RST_STATUS;
      bank_ff <= 5'h00;
    end else begin
      psw_out_ff <= psw_view;
      bank_ff <= {bank_select_high, bank_select_low, 3'h0};
    end
  end
  // outputs that are plain register copies
  assign stack_top_pointer = sp_ff;
  assign indirect_pointer = {dph_ff, dpl_ff};
  assign accumulator = acc_ff;
  assign program_status_word = psw_out_ff;
  assign bank_base = bank_ff;
  assign push_addr = push_addr_ff;
  assign push_strobe = push_strobe_ff;
  assign sfr_rdata = rdata_ff;
  assign sfr_hit = hit_ff;
endmodule : csp_core_regs

// ### verilog/csp_regs.svh
`ifndef CSP_REGS_SVH
`define CSP_REGS_SVH
// special-function addresses, all pages
`define CSP_ADDR_STACK_TOP 8'h81
`define CSP_ADDR_PTR_LOW 8'h82
`define CSP_ADDR_PTR_HIGH 8'h83
`define CSP_ADDR_STATUS 8'hd0
`define CSP_ADDR_ACCUM 8'he0
// reset values
`define CSP_RST_STACK_TOP 8'h07
`define CSP_RST_PTR_LOW 8'h00
`define CSP_RST_PTR_HIGH 8'h00
`define CSP_RST_STATUS 8'h00
`define CSP_RST_ACCUM 8'h00
// status word bit positions
`define CSP_BIT_CARRY 7
`define CSP_BIT_HALF 6
`define CSP_BIT_USER_A 5
`define CSP_BIT_BANK_HI 4
`define CSP_BIT_BANK_LO 3
`define CSP_BIT_OVERFLOW 2
`define CSP_BIT_USER_B 1
`define CSP_BIT_PARITY 0
`endif

// ### verilog/csp_pkg.sv
package csp_pkg;
  // arithmetic operation classes driven by the datapath
  typedef enum logic [2:0] {
    CSP_OP_NONE = 3'h0,
    CSP_OP_ADD = 3'h1,
    CSP_OP_ADD_WITH_CARRY = 3'h3,
    CSP_OP_SUBTRACT_WITH_BORROW = 3'h2,
    CSP_OP_MUL = 3'h6,
    CSP_OP_DIV = 3'h7,
    CSP_OP_OTHER = 3'h5
  } csp_op_t;
  typedef logic [7:0] csp_byte_t;
endpackage : csp_pkg

// ### verilog/csp_flag_unit.sv
`timescale 1ns/10ps
// flag computation for one arithmetic operation
module csp_flag_unit
  import csp_pkg::*;
(
  // operation
  input wire csp_pkg::csp_op_t op,
  input wire csp_pkg::csp_byte_t opnd_a,
  input wire csp_pkg::csp_byte_t opnd_b,
  input wire logic carry_in,
  // flags
  output logic carry_out,
  output logic half_out,
  output logic ovf_out,
  output logic ovf_touch
);
  import csp_pkg::*;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [15:0] prod;
  logic cin;
  always_comb begin
    cin = (op == CSP_OP_ADD) ? 1'b0 : carry_in;
    sum9 = 9'h000;
    sum5 = 5'h00;
    prod = 16'h0000;
    carry_out = 1'b0;
    half_out = 1'b0;
    ovf_out = 1'b0;
    ovf_touch = 1'b0;
    case (op)
      CSP_OP_ADD, CSP_OP_ADD_WITH_CARRY: begin
        sum9 = {1'b0, opnd_a} + {1'b0, opnd_b} + {8'h00, cin};
        sum5 = {1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]} + {4'h0, cin};
        carry_out = sum9[8];
        half_out = sum5[4];
        ovf_out = (opnd_a[7] == opnd_b[7]) && (sum9[7] != opnd_a[7]);
        ovf_touch = 1'b1;
      end
      CSP_OP_SUBTRACT_WITH_BORROW: begin
        sum9 = {1'b0, opnd_a} - {1'b0, opnd_b} - {8'h00, cin};
        sum5 = {1'b0, opnd_a[3:0]} - {1'b0, opnd_b[3:0]} - {4'h0, cin};
        carry_out = sum9[8];
        half_out = sum5[4];
        ovf_out = (opnd_a[7] != opnd_b[7]) && (sum9[7] != opnd_a[7]);
        ovf_touch = 1'b1;
      end
      CSP_OP_MUL: begin
        prod = {8'h00, opnd_a} * {8'h00, opnd_b};
        ovf_out = (prod[15:8] != 8'h00);
        ovf_touch = 1'b1;
      end
      CSP_OP_DIV: begin
        ovf_out = (opnd_b == 8'h00);
        ovf_touch = 1'b1;
      end
      default: begin
        carry_out = 1'b0;
      end
    endcase
  end
endmodule : csp_flag_unit

// ### bench/csp_props.sv
`timescale 1ns/10ps
module csp_props
  import csp_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register access
  input wire csp_pkg::csp_byte_t sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire csp_pkg::csp_byte_t sfr_wdata,
  input wire csp_pkg::csp_byte_t sfr_rdata,
  input wire logic sfr_hit,
  // datapath
  input wire logic push_req,
  input wire csp_pkg::csp_op_t arith_op,
  input wire csp_pkg::csp_byte_t stack_top_pointer,
  input wire csp_pkg::csp_byte_t push_addr,
  input wire logic push_strobe,
  input wire logic [15:0] indirect_pointer,
  input wire csp_pkg::csp_byte_t program_status_word,
  input wire csp_pkg::csp_byte_t accumulator,
  input wire logic [4:0] bank_base
);
  import csp_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  AST_RD_STACK: assert property (sfr_rd && sfr_addr == 8'h81 |=>
    sfr_hit && sfr_rdata == $past(stack_top_pointer)) else $error("rd");
  AST_PUSH: assert property (push_req |=> push_strobe &&
    push_addr == stack_top_pointer &&
    stack_top_pointer == $past(stack_top_pointer) + 8'h01) else $error("push");
  AST_PTR_LOW: assert property (sfr_wr && sfr_addr == 8'h82 |=>
    indirect_pointer[7:0] == $past(sfr_wdata)) else $error("ptr");
  AST_ACC_WR: assert property (sfr_wr && sfr_addr == 8'he0 |=>
    accumulator == $past(sfr_wdata)) else $error("acc");
  AST_PARITY: assert property (
    program_status_word[0] == ^$past(accumulator)) else $error("parity");
  // both copies are taken from the same stored word on the same edge
  AST_BANK: assert property (
    bank_base == {program_status_word[4:3], 3'h0}) else $error("bank");
  AST_PSW_WR: assert property (sfr_wr && sfr_addr == 8'hd0 |-> ##2
    program_status_word[7:1] == $past(sfr_wdata[7:1], 2)) else $error("psw");
  AST_OTHER: assert property (arith_op == CSP_OP_OTHER && !sfr_wr |->
    ##2 program_status_word[7:6] == 2'h0) else $error("other");
  cover property (push_req);
  cover property (sfr_rd && sfr_addr == 8'hd0);
  cover property (arith_op == CSP_OP_MUL);
endmodule : csp_props

// ### bench/csp_dp_model.sv
`timescale 1ns/10ps
// datapath stand-in: one cycle from command to port
module csp_dp_model
  import csp_pkg::*;
(
  // clock and commands
  input wire logic core_clk,
  input wire logic cmd_push,
  input wire logic cmd_load,
  input wire csp_pkg::csp_byte_t cmd_val,
  input wire csp_pkg::csp_op_t cmd_op,
  input wire csp_pkg::csp_byte_t cmd_b,
  // to the register block
  output logic push_req,
  output logic acc_load,
  output csp_pkg::csp_byte_t acc_value,
  output csp_pkg::csp_op_t arith_op,
  output csp_pkg::csp_byte_t arith_b
);
  import csp_pkg::*;
  // one process drives every output, so each has a single driver
  // unused operands toggle so a stale value is never trusted
  initial begin
    {push_req, acc_load, acc_value, arith_b} = 18'h0;
    arith_op = CSP_OP_NONE;
    forever begin
      @(posedge core_clk);
      push_req <= cmd_push;
      acc_load <= cmd_load;
      arith_op <= cmd_op;
      acc_value <= cmd_load ? cmd_val : ~acc_value;
      arith_b <= cmd_op != CSP_OP_NONE ? cmd_b : ~arith_b;
    end
  end
endmodule : csp_dp_model

// ### bench/csp_core_regs_bench.sv
`timescale 1ns/10ps
module csp_core_regs_bench;
  import csp_pkg::*;
  logic core_clk = 1'b0, rstn = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic cmd_push = 1'b0, cmd_load = 1'b0, rd_d = 1'b0;
  logic sfr_hit, push_req, acc_load, push_strobe;
  csp_byte_t sfr_addr = 8'h00, sfr_wdata = 8'h00, cmd_val = 8'h00;
  csp_byte_t cmd_b = 8'h00, lf = 8'h47, p, a, b, f, w[3];
  csp_byte_t sfr_rdata, push_addr, acc_value, arith_b, stack_top_pointer;
  csp_byte_t program_status_word, accumulator;
  csp_op_t arith_op, cmd_op = CSP_OP_NONE;
  logic [15:0] indirect_pointer;
  logic [4:0] bank_base;
  logic [8:0] notes[$];
  logic [8:0] push_notes[$];
  logic [7:0] regs[5] = '{8'h81, 8'h82, 8'h83, 8'hd0, 8'he0};
  logic [34:0] tbl[6] = '{{3'h1, 32'h04ff01c0}, {3'h3, 32'ha07f0044},
    {3'h2, 32'h000001c0}, {3'h6, 32'h00ff0204}, {3'h7, 32'hc2100004},
    {3'h5, 32'hc4010504}};
  int miscompares = 0, checked = 0, i;
  always #2 core_clk = ~core_clk;
  csp_core_regs i_csp_core_regs(.core_clk, .rstn, .sfr_addr, .sfr_wr,
    .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit, .push_req, .acc_load,
    .acc_value, .arith_op, .arith_b, .stack_top_pointer, .push_addr,
    .push_strobe, .indirect_pointer, .program_status_word, .accumulator,
    .bank_base);
  csp_dp_model i_csp_dp_model(.core_clk, .cmd_push, .cmd_load, .cmd_val,
    .cmd_op, .cmd_b, .push_req, .acc_load, .acc_value, .arith_op, .arith_b);
  function automatic csp_byte_t nxt(csp_byte_t s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : nxt
  task automatic cmp_read(logic [8:0] e, logic [8:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error read expected %h seen %h", e, g);
    end
  endtask : cmp_read
  task automatic cmp_push(logic [8:0] e, logic [8:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error push_addr expected %h seen %h", e, g);
    end
  endtask : cmp_push
  task automatic cmp_reg(string n, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_reg
  task automatic wr(csp_byte_t ad, csp_byte_t d);
    @(posedge core_clk);
    sfr_addr <= ad;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask : wr
  task automatic rd(csp_byte_t ad, logic [8:0] e);
    notes.push_back(e);
    @(posedge core_clk);
    sfr_addr <= ad;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
  endtask : rd
  task automatic dp(logic l, csp_byte_t d, csp_op_t o, csp_byte_t bb);
    @(posedge core_clk);
    cmd_push <= !l && o == CSP_OP_NONE;
    cmd_load <= l;
    cmd_val <= d;
    cmd_op <= o;
    cmd_b <= bb;
    @(posedge core_clk);
    {cmd_push, cmd_load} <= 2'h0;
    cmd_op <= CSP_OP_NONE;
    @(posedge core_clk);
  endtask : dp
  task automatic print_verdict;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  // read results land one cycle after the strobe
  // an empty note queue pops all x, which never matches a raised strobe
  always @(posedge core_clk) begin
    rd_d <= sfr_rd;
    if (rd_d) cmp_read(notes.pop_front(), {sfr_hit, sfr_rdata});
    if (push_strobe) begin
      cmp_push(push_notes.pop_front(), {push_strobe, push_addr});
    end
  end
  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    rd(8'h81, 9'h107);
    for (i = 1; i < 5; i++) rd(regs[i], 9'h100);
    rd(8'h80, 9'h000);
    for (i = 0; i < 3; i++) begin
      lf = nxt(lf);
      w[i] = lf;
      wr(regs[i], lf);
      rd(regs[i], {1'b1, lf});
    end
    cmp_reg("pointer", {w[2], w[1]}, indirect_pointer);
    wr(8'h81, 8'hff);
    push_notes.push_back(9'h100);
    dp(1'b0, 8'h00, CSP_OP_NONE, 8'h00);
    rd(8'h81, 9'h100);
    cmp_reg("push", 16'h0, push_addr);
    push_notes.push_back(9'h101);
    dp(1'b0, 8'h00, CSP_OP_NONE, 8'h00);
    rd(8'h81, 9'h101);
    cmp_reg("push", 16'h1, push_addr);
    for (i = 0; i < 4; i++) begin
      wr(8'hd0, 8'(i << 3));
      repeat (2) @(posedge core_clk);
      #1 cmp_reg("bank", 16'(i * 8), bank_base);
    end
    foreach (tbl[k]) begin
      {p, a, b, f} = tbl[k][31:0];
      dp(1'b1, a, CSP_OP_NONE, 8'h00);
      wr(8'hd0, p);
      dp(1'b0, 8'h00, csp_op_t'(tbl[k][34:32]), b);
      rd(8'hd0, {1'b1, f[7:6], p[5:3], f[2], p[1], ^a});
    end
    // reset again mid-run: registers must fall back to their reset values
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    rd(8'h81, 9'h107);
    rd(8'hd0, 9'h100);
    rd(8'he0, 9'h100);
    repeat (20) if (notes.size() != 0) @(posedge core_clk);
    if (notes.size() != 0 || push_notes.size() != 0) miscompares++;
    print_verdict();
  end
endmodule : csp_core_regs_bench
bind csp_core_regs csp_props i_csp_props(.core_clk, .rstn, .sfr_addr,
  .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit, .push_req, .arith_op,
  .stack_top_pointer, .push_addr, .push_strobe, .indirect_pointer,
  .program_status_word, .accumulator, .bank_base);
